// ==== shared/fpc_cfg.svh ====
/*
 * Named indices, field positions, key values and reset values of the
 * flat-panel control register bank.
 * Assumes it is included by bare name from design files only.
 */
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH
// ------------------------------------------------------------
// Register indices on the indexed I/O port
// ------------------------------------------------------------
`define FPC_IDX_PANEL_CTL2 8'h33
`define FPC_IDX_PANEL_KEY 8'h34
`define FPC_IDX_MAP_KEY 8'h35
`define FPC_IDX_MAP_ADDR 8'h38
`define FPC_IDX_MAP_DATA 8'h39
`define FPC_IDX_MAP_PWR 8'h3a
`define FPC_IDX_HEIGHT 8'h3b
`define FPC_IDX_BLINK 8'h3c
// ------------------------------------------------------------
// Key values
// ------------------------------------------------------------
`define FPC_PANEL_KEY_VAL 3'h5
`define FPC_SHADOW_KEY_VAL 3'h6
`define FPC_MAP_KEY_VAL 8'h30
`define FPC_KEY_PANEL_HI 6
`define FPC_KEY_PANEL_LO 4
`define FPC_KEY_SHADOW_HI 2
`define FPC_KEY_SHADOW_LO 0
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define FPC_C2_RES_HI 7
`define FPC_C2_STN_HI 6
`define FPC_C2_STN_LO 5
`define FPC_C2_RES_LO 4
`define FPC_C2_LCD4 3
`define FPC_C2_SHADE 2
`define FPC_C2_REF_CNT 1
`define FPC_C2_REF_SRC 0
`define FPC_PW_PD_SEL 7
`define FPC_PW_DIV8 6
`define FPC_PW_HREL 5
`define FPC_PW_BYPASS 3
`define FPC_PW_WEIGHT 1
`define FPC_PW_RW_MASK 8'hea
`define FPC_BL_LP_MODE 7
`define FPC_BL_SCLK_POL 6
`define FPC_BL_CHAR_HI 5
`define FPC_BL_CHAR_LO 3
`define FPC_BL_CUR_HI 2
`define FPC_BL_CUR_LO 0
// ------------------------------------------------------------
// Reset values, blink codes, weights
// ------------------------------------------------------------
`define FPC_RST_BYTE 8'h00
`define FPC_RST_INT 6'h00
`define FPC_STEP 8'h01
`define FPC_BLINK_OFF 3'h0
`define FPC_BLINK_MAX 3'h5
`define FPC_BLINK_SHIFT 4'h2
`define FPC_W_RED 16'h004d
`define FPC_W_GREEN 16'h0097
`define FPC_W_BLUE 16'h001c
`define FPC_W_SHIFT 8
`define FPC_REF_ONE 2'h1
`define FPC_REF_TWO 2'h2
`define FPC_REF_CRT 2'h0
`endif

// ==== shared/fpc_pkg.sv ====
/*
 * Types shared by the flat-panel control register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpc_pkg;
   // Panel width select, coded as {bit7, bit4} of the second control reg
   typedef enum logic [1:0] {
      FPC_W640 = 2'h0,
      FPC_WRSV = 2'h1,
      FPC_W1024 = 2'h2,
      FPC_W800 = 2'h3
   } fpc_width_type;
   // Panel kind from the STN field
   typedef enum logic [1:0] {
      FPC_NOT_STN = 2'h0,
      FPC_STN8 = 2'h1,
      FPC_STN_UNDEF = 2'h2,
      FPC_STN16 = 2'h3
   } fpc_stn_type;
endpackage

// ==== verilog/fpc_regs.sv ====
/*
 * Flat-panel control register bank: panel and mapping-RAM locks, mapping
 * RAM with auto-incrementing address, power and panel timing controls,
 * blink phase generation and intensity weighting.
 * Assumes host cycles arrive as one-cycle strobes synchronous to MCLK and
 * that FRAME_START, VBLANK and the pixel inputs come from the timing logic.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fpc_cfg.svh"
module fpc_regs (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic IO_WR,
   input wire logic IO_RD,
   input wire logic IO_BYTE,
   input wire logic [7:0] IO_INDEX,
   input wire logic [7:0] IO_WDATA,
   output logic [7:0] IO_RDATA,
   output logic IO_RVALID,
   output logic SYS_OE,
   input wire logic POWER_DOWN_INPUT,
   input wire logic GEN_PD_ENABLE,
   input wire logic CRT_MODE,
   input wire logic PLASMA_PANEL,
   input wire logic VBLANK,
   input wire logic FRAME_START,
   input wire logic [7:0] MAP_INDEX,
   output logic [7:0] MAP_SHADE,
   input wire logic [5:0] PIX_RED,
   input wire logic [5:0] PIX_GREEN,
   input wire logic [5:0] PIX_BLUE,
   output logic [5:0] INTENSITY,
   output fpc_pkg::fpc_stn_type STN_TYPE,
   output fpc_pkg::fpc_width_type PANEL_WIDTH,
   output logic SINGLE_LCD_4BIT,
   output logic SHADE_PWM,
   output logic [1:0] REFRESH_PER_LINE,
   output logic SHADOW_UNLOCKED,
   output logic SYS_POWERDOWN_SEL,
   output logic DIV8_CLK_EN,
   output logic MAP_BYPASS,
   output logic [7:0] PANEL_HEIGHT,
   output logic LINE_PULSE_EN,
   output logic SHIFT_CLK_RUN,
   output logic SHIFT_CLK_INVERT,
   output logic CHAR_BLINK_ON,
   output logic CURSOR_BLINK_ON
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0] ctl2_q;
   logic [7:0] panel_key_q;
   logic [7:0] map_key_q;
   logic [7:0] map_addr_q;
   logic [7:0] map_pwr_q;
   logic [7:0] height_q;
   logic [7:0] blink_q;
   logic [7:0] frame_cnt_q;
   logic [7:0] map_ram [0:255];
   logic panel_open;
   logic map_open;
   logic released;
   logic wr_ok;
   logic rd_ok;
   logic data_acc;
   logic [15:0] weighted;

   // Lock decode from stored keys
   // Bit 7 of the panel key is ignored, so both halves of the byte range open
   assign panel_open = (panel_key_q[`FPC_KEY_PANEL_HI:`FPC_KEY_PANEL_LO] == `FPC_PANEL_KEY_VAL);
   assign map_open = (map_key_q == `FPC_MAP_KEY_VAL);
   assign released = map_pwr_q[`FPC_PW_HREL] & ~POWER_DOWN_INPUT;
   // Released device takes no host cycle at all
   assign wr_ok = IO_WR & ~released;
   assign rd_ok = IO_RD & ~released;
   // Wide cycles at the data port neither move data nor the counter
   assign data_acc = (wr_ok | rd_ok) & map_open & IO_BYTE
                     & (IO_INDEX == `FPC_IDX_MAP_DATA);

   // ------------------------------------------------------------
   // Key registers
   // ------------------------------------------------------------
   // Keys load on any write; the open state follows the last value
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         panel_key_q <= `FPC_RST_BYTE;
         map_key_q <= `FPC_RST_BYTE;
      end else begin
         if (wr_ok && IO_INDEX == `FPC_IDX_PANEL_KEY) begin
            panel_key_q <= IO_WDATA;
         end
         if (wr_ok && IO_INDEX == `FPC_IDX_MAP_KEY) begin
            map_key_q <= IO_WDATA;
         end
      end
   end

   // ------------------------------------------------------------
   // Panel group: second control, height, blink
   // ------------------------------------------------------------
   // Writes land only while the panel key is open
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ctl2_q <= `FPC_RST_BYTE;
         height_q <= `FPC_RST_BYTE;
         blink_q <= `FPC_RST_BYTE;
      end else if (wr_ok && panel_open) begin
         if (IO_INDEX == `FPC_IDX_PANEL_CTL2) begin
            ctl2_q <= IO_WDATA;
         end
         if (IO_INDEX == `FPC_IDX_HEIGHT) begin
            height_q <= IO_WDATA;
         end
         if (IO_INDEX == `FPC_IDX_BLINK) begin
            blink_q <= IO_WDATA;
         end
      end
   end

   // ------------------------------------------------------------
   // Mapping group: address counter, data port, power control
   // ------------------------------------------------------------
   // Counter loads on its own index and steps on every data access
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         map_addr_q <= `FPC_RST_BYTE;
      end else if (data_acc) begin
         // Wraps ff to 00, so a full table load needs one address write
         map_addr_q <= map_addr_q + `FPC_STEP;
      end else if (wr_ok && map_open && IO_BYTE && IO_INDEX == `FPC_IDX_MAP_ADDR) begin
         map_addr_q <= IO_WDATA;
      end
   end

   // RAM contents are not reset; software loads the table
   always_ff @(posedge MCLK) begin
      if (data_acc && IO_WR) begin
         map_ram[map_addr_q] <= IO_WDATA;
      end
   end

   // Reserved bits of the power control never store
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         map_pwr_q <= `FPC_RST_BYTE;
      end else if (wr_ok && map_open && IO_INDEX == `FPC_IDX_MAP_PWR) begin
         map_pwr_q <= IO_WDATA & `FPC_PW_RW_MASK;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // Locked or unknown indices answer zero so nothing leaks out
   // A data port read also steps the counter; polling it walks the table
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         IO_RDATA <= `FPC_RST_BYTE;
         IO_RVALID <= 1'b0;
      end else begin
         IO_RVALID <= rd_ok;
         IO_RDATA <= `FPC_RST_BYTE;
         if (rd_ok) begin
            unique case (IO_INDEX)
               `FPC_IDX_PANEL_CTL2: IO_RDATA <= panel_open ? ctl2_q : `FPC_RST_BYTE;
               `FPC_IDX_HEIGHT: IO_RDATA <= panel_open ? height_q : `FPC_RST_BYTE;
               `FPC_IDX_BLINK: IO_RDATA <= panel_open ? blink_q : `FPC_RST_BYTE;
               `FPC_IDX_PANEL_KEY: IO_RDATA <= `FPC_RST_BYTE;
               `FPC_IDX_MAP_KEY: IO_RDATA <= map_key_q;
               `FPC_IDX_MAP_ADDR: IO_RDATA <= (map_open && IO_BYTE) ? map_addr_q : `FPC_RST_BYTE;
               `FPC_IDX_MAP_DATA: IO_RDATA <= data_acc ? map_ram[map_addr_q] : `FPC_RST_BYTE;
               `FPC_IDX_MAP_PWR: IO_RDATA <= map_open ? map_pwr_q : `FPC_RST_BYTE;
               default: IO_RDATA <= `FPC_RST_BYTE;
            endcase
         end
      end
   end

   // System interface drive enable drops while released
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         SYS_OE <= 1'b1;
      end else begin
         SYS_OE <= ~released;
      end
   end

   // ------------------------------------------------------------
   // Static control outputs
   // ------------------------------------------------------------
   // Registered copies keep every output straight from a flop
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         STN_TYPE <= fpc_pkg::FPC_NOT_STN;
         PANEL_WIDTH <= fpc_pkg::FPC_W640;
         SINGLE_LCD_4BIT <= 1'b0;
         SHADE_PWM <= 1'b0;
         REFRESH_PER_LINE <= `FPC_REF_CRT;
         SHADOW_UNLOCKED <= 1'b0;
         SYS_POWERDOWN_SEL <= 1'b0;
         DIV8_CLK_EN <= 1'b0;
         MAP_BYPASS <= 1'b0;
         PANEL_HEIGHT <= `FPC_RST_BYTE;
         SHIFT_CLK_INVERT <= 1'b0;
      end else begin
         STN_TYPE <= fpc_pkg::fpc_stn_type'(ctl2_q[`FPC_C2_STN_HI:`FPC_C2_STN_LO]);
         PANEL_WIDTH <= fpc_pkg::fpc_width_type'({ctl2_q[`FPC_C2_RES_HI], ctl2_q[`FPC_C2_RES_LO]});
         SINGLE_LCD_4BIT <= ctl2_q[`FPC_C2_LCD4];
         SHADE_PWM <= ctl2_q[`FPC_C2_SHADE];
         // Zero tells the refresh logic to follow the CRT controller
         if (!ctl2_q[`FPC_C2_REF_SRC]) begin
            REFRESH_PER_LINE <= `FPC_REF_CRT;
         end else if (ctl2_q[`FPC_C2_REF_CNT]) begin
            REFRESH_PER_LINE <= `FPC_REF_TWO;
         end else begin
            REFRESH_PER_LINE <= `FPC_REF_ONE;
         end
         SHADOW_UNLOCKED <= (panel_key_q[`FPC_KEY_SHADOW_HI:`FPC_KEY_SHADOW_LO] == `FPC_SHADOW_KEY_VAL);
         SYS_POWERDOWN_SEL <= map_pwr_q[`FPC_PW_PD_SEL];
         DIV8_CLK_EN <= map_pwr_q[`FPC_PW_DIV8] & GEN_PD_ENABLE;
         MAP_BYPASS <= map_pwr_q[`FPC_PW_BYPASS];
         PANEL_HEIGHT <= height_q;
         // Plasma panels keep the normal edge whatever software asks
         SHIFT_CLK_INVERT <= blink_q[`FPC_BL_SCLK_POL] & ~PLASMA_PANEL;
      end
   end

   // ------------------------------------------------------------
   // Line pulse and shift clock gating
   // ------------------------------------------------------------
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         LINE_PULSE_EN <= 1'b0;
         SHIFT_CLK_RUN <= 1'b0;
      end else begin
         LINE_PULSE_EN <= ~VBLANK | blink_q[`FPC_BL_LP_MODE];
         SHIFT_CLK_RUN <= ~VBLANK;
      end
   end

   // ------------------------------------------------------------
   // Blink phase
   // ------------------------------------------------------------
   // One free counter serves both rates; bit n toggles every 2**n frames
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         frame_cnt_q <= `FPC_RST_BYTE;
      end else if (FRAME_START) begin
         frame_cnt_q <= frame_cnt_q + `FPC_STEP;
      end
   end

   // Undefined codes and CRT mode leave the element steadily on
   function automatic logic blink_phase(input logic [2:0] code, input logic [7:0] cnt);
      logic [3:0] bit_sel;
      bit_sel = {1'b0, code} + `FPC_BLINK_SHIFT;
      if (code == `FPC_BLINK_OFF || code > `FPC_BLINK_MAX) begin
         blink_phase = 1'b1;
      end else begin
         blink_phase = ~cnt[bit_sel[2:0]];
      end
   endfunction

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         CHAR_BLINK_ON <= 1'b1;
         CURSOR_BLINK_ON <= 1'b1;
      end else if (CRT_MODE) begin
         CHAR_BLINK_ON <= 1'b1;
         CURSOR_BLINK_ON <= 1'b1;
      end else begin
         CHAR_BLINK_ON <= blink_phase(blink_q[`FPC_BL_CHAR_HI:`FPC_BL_CHAR_LO], frame_cnt_q);
         CURSOR_BLINK_ON <= blink_phase(blink_q[`FPC_BL_CUR_HI:`FPC_BL_CUR_LO], frame_cnt_q);
      end
   end

   // ------------------------------------------------------------
   // Gray mapping and weighting
   // ------------------------------------------------------------
   // Weights are scaled to 256 so the divide is a plain shift
   assign weighted = `FPC_W_RED * {10'h000, PIX_RED} + `FPC_W_GREEN * {10'h000, PIX_GREEN}
                     + `FPC_W_BLUE * {10'h000, PIX_BLUE};

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         INTENSITY <= `FPC_RST_INT;
         MAP_SHADE <= `FPC_RST_BYTE;
      end else begin
         // Without weighting the green channel stands for intensity
         INTENSITY <= map_pwr_q[`FPC_PW_WEIGHT] ? weighted[`FPC_W_SHIFT +: 6] : PIX_GREEN;
         MAP_SHADE <= map_pwr_q[`FPC_PW_BYPASS] ? MAP_INDEX : map_ram[MAP_INDEX];
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_data_access;
      data_acc;
   endsequence

   addr_step_a: assert property (@(posedge MCLK) disable iff (RST)
      s_data_access |=> map_addr_q == $past(map_addr_q) + `FPC_STEP)
      else $error("address counter did not step on data access");

   data_read_a: assert property (@(posedge MCLK) disable iff (RST)
      (s_data_access and rd_ok) |=> IO_RVALID && IO_RDATA == map_ram[$past(map_addr_q)])
      else $error("data port read wrong entry");

   key_hidden_a: assert property (@(posedge MCLK) disable iff (RST)
      (rd_ok && IO_INDEX == `FPC_IDX_PANEL_KEY) |=> IO_RVALID && IO_RDATA == `FPC_RST_BYTE)
      else $error("panel key register read back");

   panel_lock_a: assert property (@(posedge MCLK) disable iff (RST)
      (IO_WR && !panel_open) |=> $stable(ctl2_q) && $stable(height_q) && $stable(blink_q))
      else $error("locked panel register changed");

   map_lock_a: assert property (@(posedge MCLK) disable iff (RST)
      (!map_open && !FRAME_START) |=> $stable(map_addr_q) && $stable(map_pwr_q))
      else $error("locked mapping register changed");

   wide_ignore_a: assert property (@(posedge MCLK) disable iff (RST)
      ((IO_WR || IO_RD) && !IO_BYTE) |=> $stable(map_addr_q))
      else $error("wide cycle moved address counter");

   host_release_a: assert property (@(posedge MCLK) disable iff (RST)
      released |=> !SYS_OE && !IO_RVALID && IO_RDATA == `FPC_RST_BYTE)
      else $error("released device still answering");

   shadow_key_a: assert property (@(posedge MCLK) disable iff (RST)
      (wr_ok && IO_INDEX == `FPC_IDX_PANEL_KEY) |-> ##2
         SHADOW_UNLOCKED == ($past(IO_WDATA[`FPC_KEY_SHADOW_HI:`FPC_KEY_SHADOW_LO], 2) == `FPC_SHADOW_KEY_VAL))
      else $error("shadow unlock state wrong");

   blink_crt_a: assert property (@(posedge MCLK) disable iff (RST)
      CRT_MODE |=> CHAR_BLINK_ON && CURSOR_BLINK_ON)
      else $error("blink active in CRT mode");

   line_gate_a: assert property (@(posedge MCLK) disable iff (RST)
      (VBLANK && !blink_q[`FPC_BL_LP_MODE]) |=> !LINE_PULSE_EN && !SHIFT_CLK_RUN)
      else $error("line pulse not gated in blanking");

   div8_gate_a: assert property (@(posedge MCLK) disable iff (RST)
      !GEN_PD_ENABLE |=> !DIV8_CLK_EN)
      else $error("divider enabled without general power-down");

   plasma_pol_a: assert property (@(posedge MCLK) disable iff (RST)
      PLASMA_PANEL |=> !SHIFT_CLK_INVERT)
      else $error("shift clock inverted on plasma panel");
endmodule
`default_nettype wire

// ==== bench/fpc_host.sv ====
/*
 * Host CPU model for the indexed I/O port of the flat-panel register bank.
 * Assumes MCLK comes from the bench; every strobe is launched 1 ns after
 * a rising edge and held for exactly one edge.
 */
`timescale 1ns/1ps
`default_nettype none
module fpc_host (
   input wire logic MCLK,
   output logic IO_WR,
   output logic IO_RD,
   output logic IO_BYTE,
   output logic [7:0] IO_INDEX,
   output logic [7:0] IO_WDATA
);
   // ------------------------------------------------------------
   // Idle bus
   // ------------------------------------------------------------
   initial begin
      IO_WR = 1'b0;
      IO_RD = 1'b0;
      IO_BYTE = 1'b1;
      IO_INDEX = 8'h00;
      IO_WDATA = 8'h00;
   end
   // ------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------
   // One strobe; on release the index and data lines are inverted so stale values never match
   task automatic cyc(input logic wr, input logic [7:0] idx, input logic [7:0] dat, input logic byt);
      @(posedge MCLK);
      #1;
      IO_WR = wr;
      IO_RD = !wr;
      IO_BYTE = byt;
      IO_INDEX = idx;
      IO_WDATA = dat;
      @(posedge MCLK);
      #1;
      IO_WR = 1'b0;
      IO_RD = 1'b0;
      IO_INDEX = ~idx;
      IO_WDATA = ~dat;
   endtask
   // Normal accesses are always 8-bit cycles
   task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
      cyc(1'b1, idx, dat, 1'b1);
   endtask
   task automatic rd(input logic [7:0] idx);
      cyc(1'b0, idx, 8'h00, 1'b1);
   endtask
   // Panel key: bits 6:4 open panel group, bits 2:0 open shadow group
   task automatic panel_key(input logic open, input logic shadow);
      wr(8'h34, {1'b0, open ? 3'h5 : 3'h3, 1'b0, shadow ? 3'h6 : 3'h1});
   endtask
   // Mapping RAM key
   task automatic map_key(input logic [7:0] k);
      wr(8'h35, k);
   endtask
   // Height is loaded as line count less one
   task automatic height(input int lines);
      wr(8'h3b, 8'(lines - 1));
   endtask
endmodule
`default_nettype wire

// ==== bench/fpc_regs_tb.sv ====
/*
 * Self-checking bench of the flat-panel register bank: drives host cycles
 * through the host model, queues expected read data, checks config outputs.
 * Assumes the design package is compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module fpc_regs_tb;
   logic MCLK, RST, IO_WR, IO_RD, IO_BYTE, IO_RVALID, SYS_OE, POWER_DOWN_INPUT, GEN_PD_ENABLE;
   logic CRT_MODE, PLASMA_PANEL, VBLANK, FRAME_START, SINGLE_LCD_4BIT, SHADE_PWM, SHADOW_UNLOCKED;
   logic SYS_POWERDOWN_SEL, DIV8_CLK_EN, MAP_BYPASS, LINE_PULSE_EN, SHIFT_CLK_RUN, SHIFT_CLK_INVERT;
   logic CHAR_BLINK_ON, CURSOR_BLINK_ON;
   logic [7:0] IO_INDEX, IO_WDATA, IO_RDATA, MAP_INDEX, MAP_SHADE, PANEL_HEIGHT, d;
   logic [5:0] PIX_RED, PIX_GREEN, PIX_BLUE, INTENSITY;
   logic [1:0] REFRESH_PER_LINE;
   fpc_pkg::fpc_stn_type STN_TYPE;
   fpc_pkg::fpc_width_type PANEL_WIDTH;
   logic [7:0] q[$];
   int err_total = 0;
   int checks = 0;
   fpc_host i_host (.MCLK(MCLK), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_BYTE(IO_BYTE), .IO_INDEX(IO_INDEX),
      .IO_WDATA(IO_WDATA));
   fpc_regs i_dut (.MCLK(MCLK), .RST(RST), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_BYTE(IO_BYTE),
      .IO_INDEX(IO_INDEX), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID),
      .SYS_OE(SYS_OE), .POWER_DOWN_INPUT(POWER_DOWN_INPUT), .GEN_PD_ENABLE(GEN_PD_ENABLE),
      .CRT_MODE(CRT_MODE), .PLASMA_PANEL(PLASMA_PANEL), .VBLANK(VBLANK), .FRAME_START(FRAME_START),
      .MAP_INDEX(MAP_INDEX), .MAP_SHADE(MAP_SHADE), .PIX_RED(PIX_RED), .PIX_GREEN(PIX_GREEN),
      .PIX_BLUE(PIX_BLUE), .INTENSITY(INTENSITY), .STN_TYPE(STN_TYPE), .PANEL_WIDTH(PANEL_WIDTH),
      .SINGLE_LCD_4BIT(SINGLE_LCD_4BIT), .SHADE_PWM(SHADE_PWM), .REFRESH_PER_LINE(REFRESH_PER_LINE),
      .SHADOW_UNLOCKED(SHADOW_UNLOCKED), .SYS_POWERDOWN_SEL(SYS_POWERDOWN_SEL), .DIV8_CLK_EN(DIV8_CLK_EN),
      .MAP_BYPASS(MAP_BYPASS), .PANEL_HEIGHT(PANEL_HEIGHT), .LINE_PULSE_EN(LINE_PULSE_EN),
      .SHIFT_CLK_RUN(SHIFT_CLK_RUN), .SHIFT_CLK_INVERT(SHIFT_CLK_INVERT), .CHAR_BLINK_ON(CHAR_BLINK_ON),
      .CURSOR_BLINK_ON(CURSOR_BLINK_ON));
   // ------------------------------------------------------------
   // Clock, compare and helper tasks
   // ------------------------------------------------------------
   // 200 MHz
   always #2.5 MCLK = ~MCLK;
   task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Outputs land one edge after the strobe edge; wait two spare
   task automatic settle();
      repeat (3) @(posedge MCLK);
      #1;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      q.push_back(e);
      i_host.rd(idx);
   endtask
   // Counts output toggles over four blink half periods of frames
   task automatic blink(input logic [2:0] c, input logic crt);
      int nc, nu, e;
      logic pc, pu;
      nc = 0;
      nu = 0;
      e = (c >= 3'h1 && c <= 3'h5 && !crt) ? 4 : 0;
      i_host.wr(8'h3c, {2'b01, c, c});
      CRT_MODE = crt;
      settle();
      pc = CHAR_BLINK_ON;
      pu = CURSOR_BLINK_ON;
      repeat ((c >= 3'h1 && c <= 3'h5) ? (32 << (c - 3'h1)) : 32) begin
         FRAME_START = 1'b1;
         @(posedge MCLK);
         #1;
         FRAME_START = 1'b0;
         repeat (2) @(posedge MCLK);
         #1;
         nc += int'(CHAR_BLINK_ON !== pc);
         nu += int'(CURSOR_BLINK_ON !== pu);
         pc = CHAR_BLINK_ON;
         pu = CURSOR_BLINK_ON;
      end
      chk("char toggles", 8'(nc), 8'(e));
      chk("cursor toggles", 8'(nu), 8'(e));
      if (e == 0) chk("steady on", {6'h00, CHAR_BLINK_ON, CURSOR_BLINK_ON}, 8'h03);
      rd(8'h3c, {2'b01, c, c});
   endtask
   task automatic summarize();
      chk("pending reads", 8'(q.size()), 8'h00);
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Read monitor and watchdog
   // ------------------------------------------------------------
   // Every read answer must meet a queued note; stray answers count as errors
   always @(posedge MCLK) begin
      if (IO_RVALID === 1'b1) begin
         if (q.size() == 0) chk("unexpected IO_RDATA", 8'hff, 8'h00);
         else chk("IO_RDATA", IO_RDATA, q.pop_front());
      end
   end
   // Tests take under 4000 cycles; allow five times that
   initial begin
      #100000;
      err_total++;
      summarize();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {MCLK, GEN_PD_ENABLE, CRT_MODE, PLASMA_PANEL, VBLANK, FRAME_START} = 6'h00;
      {RST, POWER_DOWN_INPUT} = 2'b11;
      {MAP_INDEX, PIX_RED, PIX_GREEN, PIX_BLUE} = 26'h0;
      void'($urandom(78065));
      repeat (20) @(posedge MCLK);
      #1;
      RST = 1'b0;
      i_host.wr(8'h33, 8'hff);
      settle();
      chk("ctl2 locked", {STN_TYPE, PANEL_WIDTH, SINGLE_LCD_4BIT, SHADE_PWM, REFRESH_PER_LINE}, 8'h00);
      chk("pwr reset", {4'h0, SYS_OE, SYS_POWERDOWN_SEL, MAP_BYPASS, SHADOW_UNLOCKED}, 8'h08);
      rd(8'h33, 8'h00);
      i_host.panel_key(1'b1, 1'b0);
      rd(8'h34, 8'h00);
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         d[1:0] = 2'(i);
         d[7] = i[2];
         d[4] = i[0] ^ i[1];
         d[6:5] = 2'(i) | {2{i[1]}};
         i_host.wr(8'h33, d);
         settle();
         chk("ctl2", {STN_TYPE, PANEL_WIDTH, SINGLE_LCD_4BIT, SHADE_PWM, REFRESH_PER_LINE},
            {d[6:5], d[7], d[4], d[3], d[2], d[0] ? (d[1] ? 2'h2 : 2'h1) : 2'h0});
         rd(8'h33, d);
      end
      i_host.panel_key(1'b0, 1'b1);
      settle();
      chk("shadow open", {7'h0, SHADOW_UNLOCKED}, 8'h01);
      rd(8'h33, 8'h00);
      i_host.panel_key(1'b1, 1'b0);
      settle();
      chk("shadow shut", {7'h0, SHADOW_UNLOCKED}, 8'h00);
      rd(8'h38, 8'h00);
      i_host.map_key(8'h30);
      rd(8'h35, 8'h30);
      i_host.wr(8'h38, 8'hfe);
      i_host.wr(8'h39, 8'haa);
      i_host.wr(8'h39, 8'hbb);
      rd(8'h38, 8'h00);
      i_host.wr(8'h38, 8'hfe);
      rd(8'h39, 8'haa);
      rd(8'h39, 8'hbb);
      i_host.cyc(1'b1, 8'h38, 8'h55, 1'b0);
      q.push_back(8'h00);
      i_host.cyc(1'b0, 8'h39, 8'h00, 1'b0);
      rd(8'h38, 8'h00);
      MAP_INDEX = 8'hfe;
      settle();
      chk("MAP_SHADE", MAP_SHADE, 8'haa);
      i_host.map_key(8'h31);
      rd(8'h38, 8'h00);
      i_host.wr(8'h38, 8'h12);
      i_host.map_key(8'h30);
      rd(8'h38, 8'h00);
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom) & 8'hdf;
         d[1] = i[1];
         GEN_PD_ENABLE = i[0];
         {PIX_RED, PIX_GREEN, PIX_BLUE} = 18'($urandom);
         i_host.wr(8'h3a, d);
         settle();
         chk("pwr", {5'h0, SYS_POWERDOWN_SEL, DIV8_CLK_EN, MAP_BYPASS}, {5'h0, d[7], d[6] & i[0], d[3]});
         chk("INTENSITY", {2'h0, INTENSITY}, d[1] ? 8'((77 * PIX_RED + 151 * PIX_GREEN + 28 * PIX_BLUE) >> 8)
            : {2'h0, PIX_GREEN});
         chk("MAP_SHADE", MAP_SHADE, d[3] ? 8'hfe : 8'haa);
         rd(8'h3a, d & 8'hca);
      end
      i_host.height(480 / 2);
      settle();
      chk("PANEL_HEIGHT", PANEL_HEIGHT, 8'hef);
      rd(8'h3b, 8'hef);
      for (int j = 0; j < 8; j++) begin
         {VBLANK, PLASMA_PANEL} = {j[0], j[1]};
         d = {j[2], j[2] ^ j[0], 6'h09};
         i_host.wr(8'h3c, d);
         settle();
         chk("lp sclk", {5'h0, LINE_PULSE_EN, SHIFT_CLK_RUN, SHIFT_CLK_INVERT},
            {5'h0, d[7] | ~j[0], ~j[0], d[6] & ~j[1]});
      end
      VBLANK = 1'b0;
      for (int c = 0; c < 8; c++) blink(3'(c), 1'b0);
      blink(3'h1, 1'b1);
      CRT_MODE = 1'b0;
      POWER_DOWN_INPUT = 1'b0;
      i_host.wr(8'h3a, 8'h20);
      settle();
      chk("SYS_OE released", {7'h0, SYS_OE}, 8'h00);
      i_host.rd(8'h3b);
      i_host.wr(8'h3b, 8'h11);
      POWER_DOWN_INPUT = 1'b1;
      settle();
      chk("SYS_OE back", {7'h0, SYS_OE}, 8'h01);
      rd(8'h3b, 8'hef);
      settle();
      summarize();
   end
endmodule
`default_nettype wire
